// ==== logic/ccc_cfg_map.svh ====
// Constants for the clock conditioner dynamic configuration loader
`ifndef CLK_COND_CFG_MAP_SVH
`define CLK_COND_CFG_MAP_SVH
`define CFG_WORD_BITS   81
`define CFG_RESET_WORD  81'h0
`define DLY_SEL_BITS    5
`define DLY_SEL_LSB     0
`define FB_SEL_BIT      5
`define DLY_STAGES      32
`define SHIFT_CNT_BITS  7
`define SHIFT_CNT_ZERO  7'h00
`define SHIFT_CNT_ONE   7'h01
`define SHIFT_CNT_FULL  7'h51
`endif

// ==== logic/ccc_cfg_pkg.sv ====
// Types shared by the clock conditioner configuration loader
`include "ccc_cfg_map.svh"
package clk_cond_cfg_pkg;
    typedef logic [`CFG_WORD_BITS-1:0] cfg_word_t;
    typedef struct packed {
        logic serial_in;
        logic shift_enable;
        logic apply_strobe;
    } cfg_port_s;
    typedef enum logic [0:0] {
        FB_INTERNAL = 1'b0,
        FB_EXTERNAL = 1'b1
    } fb_sel_e;
endpackage : clk_cond_cfg_pkg

// ==== logic/level_sync.sv ====
// Three-stage synchroniser for a level crossing into the clk domain
`timescale 1ns/10ps
module level_sync
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic d,
    output logic      q
);
    logic s1;
    logic s2;
    logic s3;

    // Change is accepted once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q  <= 1'b0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q <= s3;
        end
    end
endmodule : level_sync

// ==== logic/clock_conditioner_dyn_config.sv ====
// Dynamic configuration shift path, delay-only clock path and feedback select
`timescale 1ns/10ps
`include "ccc_cfg_map.svh"
// Overview of operation
// - Configuration held in 81-bit shift register
// - Serial output shows register LSB first
// - Shift only while enable high, else hold
// - Apply strobe loads shifted word into circuit
// - Delay path: reference clock to global through the selected tap; taps add no delay here
// - External feedback replaces internal feedback
module clock_conditioner_dyn_config
(
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        cfg_shift_clk,
    input  wire clk_cond_cfg_pkg::cfg_port_s cfg_port,
    output logic                             cfg_serial_out,
    input  wire logic                        pll_reference_clock,
    input  wire logic                        external_feedback_input,
    input  wire logic                        internal_feedback,
    output logic                             global_clock_out,
    output logic                             phase_ref,
    output logic                             phase_fb,
    output clk_cond_cfg_pkg::cfg_word_t      active_cfg,
    output logic                             cfg_applied
);
    import clk_cond_cfg_pkg::*;

    cfg_word_t shift_reg;
    logic      apply_tgl;
    logic      apply_lvl;
    logic      apply_seen;
    logic      apply_pulse;
    logic      sreset_sclk;

    // Shift-clock domain: reset is carried over with its own synchroniser
    level_sync u_rst_sync
    (
        .clk  (cfg_shift_clk),
        .srst (1'b0),
        .d    (srst),
        .q    (sreset_sclk)
    );

    wire cfg_word_t next_shift_reg = {cfg_port.serial_in,
                                      shift_reg[`CFG_WORD_BITS-1:1]};

    always_ff @(posedge cfg_shift_clk)
    begin
        if (sreset_sclk)
            shift_reg <= `CFG_RESET_WORD;
        else if (cfg_port.shift_enable)
            shift_reg <= next_shift_reg;
    end

    assign cfg_serial_out = shift_reg[0];

    // Bits shifted since the last apply; it only feeds a cover, so it
    // saturates at one full word instead of wrapping
    logic [`SHIFT_CNT_BITS-1:0] shift_cnt;
    wire                        full_word = (shift_cnt == `SHIFT_CNT_FULL);

    always_ff @(posedge cfg_shift_clk)
    begin
        if (sreset_sclk || cfg_port.apply_strobe)
            shift_cnt <= `SHIFT_CNT_ZERO;
        else if (cfg_port.shift_enable && !full_word)
            shift_cnt <= shift_cnt + `SHIFT_CNT_ONE;
    end

    // Strobe becomes a toggle so it survives the crossing; the word is stable
    // by then because the host stops shifting before it strobes
    always_ff @(posedge cfg_shift_clk)
    begin
        if (sreset_sclk)
            apply_tgl <= 1'b0;
        else if (cfg_port.apply_strobe)
            apply_tgl <= ~apply_tgl;
    end

    level_sync u_apply_sync
    (
        .clk  (clk),
        .srst (srst),
        .d    (apply_tgl),
        .q    (apply_lvl)
    );

    assign apply_pulse = apply_lvl ^ apply_seen;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            apply_seen  <= 1'b0;
            active_cfg  <= `CFG_RESET_WORD;
            cfg_applied <= 1'b0;
        end
        else
        begin
            apply_seen  <= apply_lvl;
            cfg_applied <= apply_pulse;
            if (apply_pulse)
                active_cfg <= shift_reg;
        end
    end

    // Delay-only path: tap line of behavioural buffer stages
    // Limitation: the stages carry no delay here, so every tap looks alike in
    // a functional run; the selection only matters on real delay cells
    wire [`DLY_SEL_BITS-1:0] dly_sel = active_cfg[`DLY_SEL_LSB +: `DLY_SEL_BITS];
    logic [`DLY_STAGES-1:0] tap;
    assign tap[0] = pll_reference_clock;
    genvar gi;
    generate
        for (gi = 1; gi < `DLY_STAGES; gi++)
        begin : g_tap
            assign tap[gi] = tap[gi-1];
        end
    endgenerate
    assign global_clock_out = tap[dly_sel];

    wire fb_sel_e fb_sel = fb_sel_e'(active_cfg[`FB_SEL_BIT]);
    assign phase_ref = pll_reference_clock;
    assign phase_fb  = (fb_sel == FB_EXTERNAL) ? external_feedback_input
                                               : internal_feedback;

    // Shift clock side checks
    chk_hold_idle: assert property (
        @(posedge cfg_shift_clk) disable iff (sreset_sclk)
        !cfg_port.shift_enable |=> $stable(shift_reg))
        else $error("shift register moved while enable low");

    chk_shift_in: assert property (
        @(posedge cfg_shift_clk) disable iff (sreset_sclk)
        cfg_port.shift_enable |=> shift_reg[`CFG_WORD_BITS-1] == $past(cfg_port.serial_in))
        else $error("serial bit not captured at top");

    chk_serial_out: assert property (
        @(posedge cfg_shift_clk) disable iff (sreset_sclk)
        cfg_port.shift_enable |=> cfg_serial_out == $past(shift_reg[1]))
        else $error("serial output not advancing lsb first");

    chk_out_hold: assert property (
        @(posedge cfg_shift_clk) disable iff (sreset_sclk)
        !cfg_port.shift_enable |=> $stable(cfg_serial_out))
        else $error("serial output moved while enable low");

    chk_tgl_flip: assert property (
        @(posedge cfg_shift_clk) disable iff (sreset_sclk)
        cfg_port.apply_strobe |=> apply_tgl != $past(apply_tgl))
        else $error("apply strobe not passed to the crossing");

    chk_tgl_hold: assert property (
        @(posedge cfg_shift_clk) disable iff (sreset_sclk)
        !cfg_port.apply_strobe |=> $stable(apply_tgl))
        else $error("apply request raised without strobe");

    // No disable here: these watch the reset itself
    chk_shift_reset: assert property (
        @(posedge cfg_shift_clk)
        sreset_sclk |=> shift_reg == `CFG_RESET_WORD)
        else $error("shift register not cleared by reset");

    chk_reset_clear: assert property (
        @(posedge clk)
        srst |=> active_cfg == `CFG_RESET_WORD && !cfg_applied)
        else $error("active word not cleared by reset");

    // System clock side checks
    chk_active_hold: assert property (
        @(posedge clk) disable iff (srst)
        !apply_pulse |=> $stable(active_cfg))
        else $error("active word changed without apply");

    chk_apply_load: assert property (
        @(posedge clk) disable iff (srst)
        apply_pulse |=> cfg_applied && active_cfg == $past(shift_reg))
        else $error("apply did not load shifted word");

    chk_fb_select: assert property (
        @(posedge clk) disable iff (srst)
        active_cfg[`FB_SEL_BIT] |-> phase_fb == external_feedback_input)
        else $error("external feedback not selected");

    chk_fb_internal: assert property (
        @(posedge clk) disable iff (srst)
        !active_cfg[`FB_SEL_BIT] |-> phase_fb == internal_feedback)
        else $error("internal feedback not selected");

    chk_delay_path: assert property (
        @(posedge clk) disable iff (srst)
        global_clock_out == pll_reference_clock)
        else $error("delay path lost the reference clock");

    // Main scenarios
    cov_shift: cover property (@(posedge cfg_shift_clk) cfg_port.shift_enable [*8]);

    cov_full_word: cover property (@(posedge cfg_shift_clk)
        cfg_port.apply_strobe && full_word);

    cov_apply: cover property (@(posedge clk) apply_pulse);

    cov_ext_fb: cover property (@(posedge clk) active_cfg[`FB_SEL_BIT]);

    cov_int_fb: cover property (@(posedge clk)
        cfg_applied && !active_cfg[`FB_SEL_BIT]);
endmodule : clock_conditioner_dyn_config

// ==== verif/cfg_user_model.sv ====
// User-logic model that drives the loader's shift port
`timescale 1ns/10ps
module cfg_user_model
(
    output logic                        cfg_shift_clk,
    output clk_cond_cfg_pkg::cfg_port_s cfg_port,
    input  wire logic                   cfg_serial_out
);
    import clk_cond_cfg_pkg::*;
    cfg_word_t got;
    initial
    begin
        cfg_port = '0;
        cfg_shift_clk = 1'b0;
        // Odd start offset keeps the edges clear of the system clock
        #7;
        forever #15 cfg_shift_clk = ~cfg_shift_clk;
    end
    // Shift bits lo..hi-1 and record what the loader emits meanwhile
    task automatic load(input cfg_word_t w, input int lo, input int hi);
        for (int i = lo; i < hi; i++)
        begin
            @(posedge cfg_shift_clk);
            cfg_port.serial_in    <= w[i];
            cfg_port.shift_enable <= 1'b1;
            @(negedge cfg_shift_clk);
            got[i] = cfg_serial_out;
        end
        @(posedge cfg_shift_clk);
        cfg_port.shift_enable <= 1'b0;
        // Idle data is flipped from the last bit so a stray shift cannot go unnoticed
        cfg_port.serial_in <= ~cfg_port.serial_in;
    endtask : load
    task automatic apply();
        @(posedge cfg_shift_clk);
        cfg_port.apply_strobe <= 1'b1;
        @(posedge cfg_shift_clk);
        cfg_port.apply_strobe <= 1'b0;
    endtask : apply
endmodule : cfg_user_model

// ==== verif/tb_clock_conditioner_dyn_config.sv ====
// Bench for the clock conditioner configuration loader
`timescale 1ns/10ps
module tb_clock_conditioner_dyn_config;
    import clk_cond_cfg_pkg::*;
    logic      clk = 1'b0, srst = 1'b1, cfg_shift_clk, cfg_serial_out, cfg_applied;
    logic      pll_reference_clock = 1'b0, external_feedback_input = 1'b0;
    logic      internal_feedback = 1'b1, global_clock_out, phase_ref, phase_fb;
    cfg_port_s cfg_port;
    cfg_word_t active_cfg, prev;
    int        n_errors = 0, checks_done = 0;
    cfg_word_t words [4] = '{81'h0_0000_0000_0000_0000_0021, 81'h1_ffff_ffff_ffff_ffff_ffde,
                             81'h0_a5a5_5a5a_a5a5_5a5a_3c3f, 81'h1_0000_0000_0000_0000_0000};
    logic      fb_ext [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    clock_conditioner_dyn_config u_clock_conditioner_dyn_config
    (
        .clk, .srst, .cfg_shift_clk, .cfg_port, .cfg_serial_out, .pll_reference_clock,
        .external_feedback_input, .internal_feedback, .global_clock_out, .phase_ref,
        .phase_fb, .active_cfg, .cfg_applied
    );
    cfg_user_model u_cfg_user_model (.cfg_shift_clk, .cfg_port, .cfg_serial_out);
    always #50 clk = ~clk;
    // Two feedback sources always differ, so the selection is visible
    always @(posedge clk)
    begin
        pll_reference_clock     <= ~pll_reference_clock;
        external_feedback_input <= ~pll_reference_clock;
        internal_feedback       <= pll_reference_clock;
    end
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check
    task automatic apply_word(input cfg_word_t w);
        u_cfg_user_model.apply();
        for (int n = 0; n < 30 && cfg_applied !== 1'b1; n++)
            @(negedge clk);
        check(cfg_applied === 1'b1 && active_cfg === w, "apply");
        check(global_clock_out === pll_reference_clock, "delay path");
        check(phase_ref === pll_reference_clock, "phase ref");
    endtask : apply_word
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(negedge clk);
        check(active_cfg === '0 && cfg_applied === 1'b0, "reset");
        prev = '0;
        for (int r = 0; r < 4; r++)
        begin
            u_cfg_user_model.load(words[r], 0, 81);
            check(active_cfg === prev, "word moved early");
            check(u_cfg_user_model.got === prev, "shift out");
            apply_word(words[r]);
            check(phase_fb === (fb_ext[r] ? external_feedback_input : internal_feedback), "fb");
            prev = words[r];
        end
        // Pause with enable low in mid-word; held bits must not move
        u_cfg_user_model.load(~prev, 0, 40);
        repeat (10) @(posedge cfg_shift_clk);
        check(active_cfg === prev && cfg_applied === 1'b0, "paused");
        u_cfg_user_model.load(~prev, 40, 81);
        check(u_cfg_user_model.got === prev, "split shift out");
        apply_word(~prev);
        // Reset in mid-run clears both domains; shifting works again after it
        @(posedge clk);
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(negedge clk);
        check(active_cfg === '0 && cfg_applied === 1'b0, "mid reset");
        check(cfg_serial_out === 1'b0 && phase_fb === internal_feedback, "mid pins");
        u_cfg_user_model.load(words[2], 0, 81);
        check(u_cfg_user_model.got === '0, "shift out after reset");
        apply_word(words[2]);
        stop_test();
    end
endmodule : tb_clock_conditioner_dyn_config
